// ---- hdl/ufmt_pkg.sv ----
package ufmt_pkg;

   // Register word indices on the plain register port.
   localparam logic [2:0] ADDR_SOURCE_STATUS = 3'h0;
   localparam logic [2:0] ADDR_FORMAT_CTRL   = 3'h1;
   localparam logic [2:0] ADDR_EVENT_STATUS  = 3'h2;
   localparam logic [2:0] ADDR_EVENT_MASK    = 3'h3;

   // Reset values.
   localparam logic [7:0] FORMAT_CTRL_RESET = 8'h00;
   localparam logic [7:0] SOURCE_IDLE_RESET = 8'h01;
   localparam logic [6:0] EVENT_RESET       = 7'h00;

   // Format control field positions.
   localparam int FMT_DIVISOR_BIT = 7;
   localparam int FMT_BREAK_BIT   = 6;
   localparam int FMT_FORCE_BIT   = 5;
   localparam int FMT_EVEN_BIT    = 4;
   localparam int FMT_PARITY_BIT  = 3;
   localparam int FMT_STOP_BIT    = 2;
   localparam int FMT_LEN_MSB     = 1;

   // Interrupt source indices, highest priority first.
   localparam int SRC_COUNT    = 7;
   localparam int SRC_LINE_ERR = 0;
   localparam int SRC_RX_DATA  = 1;
   localparam int SRC_RX_TMO   = 2;
   localparam int SRC_TX_EMPTY = 3;
   localparam int SRC_MODEM    = 4;
   localparam int SRC_XOFF     = 5;
   localparam int SRC_FLOW     = 6;

   // Source codes for status bits 5 to 1.
   localparam logic [4:0] CODE_LINE_ERR = 5'h03;
   localparam logic [4:0] CODE_RX_DATA  = 5'h02;
   localparam logic [4:0] CODE_RX_TMO   = 5'h06;
   localparam logic [4:0] CODE_TX_EMPTY = 5'h01;
   localparam logic [4:0] CODE_MODEM    = 5'h00;
   localparam logic [4:0] CODE_XOFF     = 5'h08;
   localparam logic [4:0] CODE_FLOW     = 5'h10;

   // Stop length in half bit times.
   localparam logic [2:0] STOP_HALVES_ONE      = 3'h2;
   localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
   localparam logic [2:0] STOP_HALVES_TWO      = 3'h4;

   // Word length encodings and data bit counts.
   localparam logic [1:0] LEN_FIVE  = 2'h0;
   localparam logic [3:0] BITS_FIVE = 4'h5;

   typedef struct packed {
      logic lineErr;
      logic rxData;
      logic rxTimeout;
      logic txEmpty;
      logic modemChange;
      logic xoffSeen;
      logic flowChange;
   } ufmt_event_type;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wrData;
      logic       wrStrobe;
      logic       rdStrobe;
   } ufmt_bus_type;

   typedef struct packed {
      logic       divisorOpen;
      logic       parityOn;
      logic       parityForced;
      logic       paritySense;
      logic [3:0] dataBits;
      logic [2:0] stopHalves;
   } ufmt_format_type;

endpackage : ufmt_pkg

// ---- hdl/ufmt_core.sv ----
// Function
// - Rank pending sources in seven levels; status read shows code of the source latched as highest pending.
// - Status read clears only the reported source, except Xoff, which waits for Xon; lower ones appear on later reads.
// - While a reported source is unserviced, no other source replaces it.
// - Bits 3..1: line error 011, rx data 010, rx timeout 110, tx empty 001.
// - Modem change reads zero, Xoff sets bit 4, CTS/RTS change sets bit 5.
// - Bits 5 and 4 only active while flow-control enable is set.
// - Bit 0 reads 0 while any reportable source pending, 1 when idle; reset value 1.
// - Format bit 7 steers accesses to divisor latch and enhanced registers; here it only drives format.divisorOpen.
// - Format bit 6 forces transmit line low as break until cleared.
// - Format bit 3 adds parity on transmit and checks it on receive.
// - Bit 4 picks odd (0) or even (1) parity when not forced.
// - With bit 5 set, parity is fixed: 1 when bit 4 is 0, else 0.
// - Bit 2: one stop bit, or 1.5 for 5-bit and 2 for longer characters.
// - Bits 1 and 0 choose the word length for transmit and receive.
// - Word length 00..11 means 5, 6, 7, 8 data bits.
// - Every format bit resets to 0.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ufmt_core (
   // Clock and reset.
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   // Register port.
   input  wire ufmt_pkg::ufmt_bus_type   bus,
   output logic [7:0]                    rdData,
   // Interrupt sources from the channel.
   input  wire ufmt_pkg::ufmt_event_type events,
   input  wire logic                     xonSeen,
   input  wire logic                     fifoEnabled,
   input  wire logic                     flowCtlEnable,
   // Serial format and line.
   input  wire logic                     txSerialIn,
   input  wire logic [7:0]               txChar,
   input  wire logic [7:0]               rxChar,
   input  wire logic                     rxParityIn,
   output ufmt_pkg::ufmt_format_type     format,
   output logic                          txLine,
   output logic                          txParityBit,
   output logic                          rxParityError,
   // Interrupt output.
   output logic                          irq
);

   typedef struct packed {
      logic [7:0]                     fmt;
      logic [ufmt_pkg::SRC_COUNT-1:0] pend;
      logic [2:0]                     cur;
      logic                           curValid;
      logic [ufmt_pkg::SRC_COUNT-1:0] evtSt;
      logic [ufmt_pkg::SRC_COUNT-1:0] evtMask;
      logic [7:0]                     rd;
      ufmt_pkg::ufmt_format_type      fmtOut;
      logic                           tx;
      logic                           txPar;
      logic                           rxPerr;
      logic                           irq;
   } ufmt_state_type;

   ufmt_state_type st_q;
   ufmt_state_type st_d;

   // Event pulses placed by name at their source index, highest priority at index 0.
   function automatic logic [ufmt_pkg::SRC_COUNT-1:0] event_vector(input ufmt_pkg::ufmt_event_type evt);
      logic [ufmt_pkg::SRC_COUNT-1:0] vec;
      vec                         = '0;
      vec[ufmt_pkg::SRC_LINE_ERR] = evt.lineErr;
      vec[ufmt_pkg::SRC_RX_DATA]  = evt.rxData;
      vec[ufmt_pkg::SRC_RX_TMO]   = evt.rxTimeout;
      vec[ufmt_pkg::SRC_TX_EMPTY] = evt.txEmpty;
      vec[ufmt_pkg::SRC_MODEM]    = evt.modemChange;
      vec[ufmt_pkg::SRC_XOFF]     = evt.xoffSeen;
      vec[ufmt_pkg::SRC_FLOW]     = evt.flowChange;
      return vec;
   endfunction : event_vector

   // Pending sources that may be reported; the two flow-control sources need the enable.
   function automatic logic [ufmt_pkg::SRC_COUNT-1:0] live_sources(input logic [ufmt_pkg::SRC_COUNT-1:0] pend,
                                                                   input logic                           flowOn);
      logic [ufmt_pkg::SRC_COUNT-1:0] live;
      live                     = pend;
      live[ufmt_pkg::SRC_XOFF] = pend[ufmt_pkg::SRC_XOFF] & flowOn;
      live[ufmt_pkg::SRC_FLOW] = pend[ufmt_pkg::SRC_FLOW] & flowOn;
      return live;
   endfunction : live_sources

   // Index of the highest-priority source that may be reported.
   function automatic logic [3:0] pick_source(input logic [ufmt_pkg::SRC_COUNT-1:0] live);
      logic [3:0] idx;
      idx = 4'hF;
      for (int i = ufmt_pkg::SRC_COUNT - 1; i >= 0; i--) begin
         if (live[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : pick_source

   // Code for status bits 5 to 1 of a source.
   function automatic logic [4:0] source_code(input logic [2:0] idx);
      logic [4:0] code;
      case (idx)
         3'(ufmt_pkg::SRC_LINE_ERR): code = ufmt_pkg::CODE_LINE_ERR;
         3'(ufmt_pkg::SRC_RX_DATA):  code = ufmt_pkg::CODE_RX_DATA;
         3'(ufmt_pkg::SRC_RX_TMO):   code = ufmt_pkg::CODE_RX_TMO;
         3'(ufmt_pkg::SRC_TX_EMPTY): code = ufmt_pkg::CODE_TX_EMPTY;
         3'(ufmt_pkg::SRC_XOFF):     code = ufmt_pkg::CODE_XOFF;
         3'(ufmt_pkg::SRC_FLOW):     code = ufmt_pkg::CODE_FLOW;
         default:                    code = ufmt_pkg::CODE_MODEM;
      endcase
      return code;
   endfunction : source_code

   // Source status word: FIFO flags, code of the reported source and the idle flag.
   function automatic logic [7:0] status_word(input logic live, input logic [2:0] idx, input logic fifoOn);
      logic [7:0] word;
      word      = 8'h00;
      word[7:6] = {2{fifoOn}};
      word[0]   = !live;
      if (live) begin
         word[5:1] = source_code(idx);
      end
      return word;
   endfunction : status_word

   // Data bits that take part in parity for each word length.
   function automatic logic [7:0] length_mask(input logic [1:0] len);
      logic [7:0] mask;
      case (len)
         2'h0:    mask = 8'h1F;
         2'h1:    mask = 8'h3F;
         2'h2:    mask = 8'h7F;
         default: mask = 8'hFF;
      endcase
      return mask;
   endfunction : length_mask

   // Parity bit over the active data bits under the current format.
   function automatic logic parity_of(input logic [7:0] data, input logic [7:0] fmt);
      logic [7:0] mask;
      logic       ones;
      mask = length_mask(fmt[ufmt_pkg::FMT_LEN_MSB:0]);
      ones = ^(data & mask);
      if (fmt[ufmt_pkg::FMT_FORCE_BIT]) begin
         return ~fmt[ufmt_pkg::FMT_EVEN_BIT];
      end
      // Odd sense makes the total count of ones odd, even sense makes it even.
      return fmt[ufmt_pkg::FMT_EVEN_BIT] ? ones : ~ones;
   endfunction : parity_of

   // Stop length in half bit times; the long setting depends on the word length.
   function automatic logic [2:0] stop_halves(input logic [7:0] fmt);
      logic [2:0] halves;
      if (!fmt[ufmt_pkg::FMT_STOP_BIT]) begin
         halves = ufmt_pkg::STOP_HALVES_ONE;
      end else if (fmt[ufmt_pkg::FMT_LEN_MSB:0] == ufmt_pkg::LEN_FIVE) begin
         halves = ufmt_pkg::STOP_HALVES_ONE_HALF;
      end else begin
         halves = ufmt_pkg::STOP_HALVES_TWO;
      end
      return halves;
   endfunction : stop_halves

   logic [ufmt_pkg::SRC_COUNT-1:0] liveNow;
   logic [ufmt_pkg::SRC_COUNT-1:0] evtVec;
   logic [3:0]                     bestIdx;
   logic                           rdSource;
   logic                           curLive;

   always_comb begin
      st_d     = st_q;
      liveNow  = live_sources(st_q.pend, flowCtlEnable);
      evtVec   = event_vector(events);
      bestIdx  = pick_source(liveNow);
      rdSource = bus.rdStrobe && (bus.addr == ufmt_pkg::ADDR_SOURCE_STATUS);
      curLive  = st_q.curValid && liveNow[st_q.cur];

      // Latch the reported source and hold it until it is serviced.
      if (!curLive) begin
         st_d.curValid = !bestIdx[3];
         st_d.cur      = bestIdx[2:0];
      end

      // Status read clears only the reported source; Xoff waits for Xon.
      if (rdSource && curLive && (st_q.cur != 3'(ufmt_pkg::SRC_XOFF))) begin
         st_d.pend[st_q.cur] = 1'b0;
         st_d.curValid       = 1'b0;
      end
      if (xonSeen) begin
         st_d.pend[ufmt_pkg::SRC_XOFF] = 1'b0;
      end
      // New events win over any clear in the same cycle.
      st_d.pend  = st_d.pend | evtVec;
      st_d.evtSt = st_q.evtSt | events;

      if (bus.wrStrobe) begin
         case (bus.addr)
            ufmt_pkg::ADDR_FORMAT_CTRL:  st_d.fmt = bus.wrData;
            ufmt_pkg::ADDR_EVENT_STATUS: st_d.evtSt = (st_q.evtSt & ~bus.wrData[6:0]) | events;
            ufmt_pkg::ADDR_EVENT_MASK:   st_d.evtMask = bus.wrData[6:0];
            default:                     st_d.fmt = st_q.fmt;
         endcase
      end

      st_d.rd = 8'h00;
      if (bus.rdStrobe) begin
         case (bus.addr)
            ufmt_pkg::ADDR_SOURCE_STATUS: st_d.rd = status_word(curLive, st_q.cur, fifoEnabled);
            ufmt_pkg::ADDR_FORMAT_CTRL:  st_d.rd = st_q.fmt;
            ufmt_pkg::ADDR_EVENT_STATUS: st_d.rd = {1'b0, st_q.evtSt};
            ufmt_pkg::ADDR_EVENT_MASK:   st_d.rd = {1'b0, st_q.evtMask};
            default:                     st_d.rd = 8'h00;
         endcase
      end

      st_d.fmtOut.divisorOpen  = st_q.fmt[ufmt_pkg::FMT_DIVISOR_BIT];
      st_d.fmtOut.parityOn     = st_q.fmt[ufmt_pkg::FMT_PARITY_BIT];
      st_d.fmtOut.parityForced = st_q.fmt[ufmt_pkg::FMT_FORCE_BIT];
      st_d.fmtOut.paritySense  = st_q.fmt[ufmt_pkg::FMT_EVEN_BIT];
      st_d.fmtOut.dataBits     = ufmt_pkg::BITS_FIVE + {2'h0, st_q.fmt[ufmt_pkg::FMT_LEN_MSB:0]};
      st_d.fmtOut.stopHalves   = stop_halves(st_q.fmt);

      st_d.tx     = st_q.fmt[ufmt_pkg::FMT_BREAK_BIT] ? 1'b0 : txSerialIn;
      st_d.txPar  = st_q.fmt[ufmt_pkg::FMT_PARITY_BIT] && parity_of(txChar, st_q.fmt);
      st_d.rxPerr = st_q.fmt[ufmt_pkg::FMT_PARITY_BIT] &&
                    (parity_of(rxChar, st_q.fmt) != rxParityIn);
      st_d.irq    = |(st_q.evtSt & st_q.evtMask);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q.fmt     <= ufmt_pkg::FORMAT_CTRL_RESET;
         st_q.pend    <= ufmt_pkg::EVENT_RESET;
         st_q.cur     <= 3'h0;
         st_q.curValid <= 1'b0;
         st_q.evtSt   <= ufmt_pkg::EVENT_RESET;
         st_q.evtMask <= ufmt_pkg::EVENT_RESET;
         st_q.rd      <= 8'h00;
         st_q.fmtOut  <= '{divisorOpen: 1'b0, parityOn: 1'b0, parityForced: 1'b0, paritySense: 1'b0,
                           dataBits: ufmt_pkg::BITS_FIVE, stopHalves: ufmt_pkg::STOP_HALVES_ONE};
         st_q.tx      <= 1'b1;
         st_q.txPar   <= 1'b0;
         st_q.rxPerr  <= 1'b0;
         st_q.irq     <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdData        = st_q.rd;
   assign format        = st_q.fmtOut;
   assign txLine        = st_q.tx;
   assign txParityBit   = st_q.txPar;
   assign rxParityError = st_q.rxPerr;
   assign irq           = st_q.irq;

endmodule : ufmt_core

`default_nettype wire

// ---- tb/ufmt_core_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module ufmt_core_sva (
   // Clock and reset.
   input wire logic                      sys_clk,
   input wire logic                      sys_rst,
   // Observed ports.
   input wire ufmt_pkg::ufmt_bus_type    bus,
   input wire logic [7:0]                rdData,
   input wire logic                      fifoEnabled,
   input wire logic                      flowCtlEnable,
   input wire logic                      txSerialIn,
   input wire ufmt_pkg::ufmt_format_type format,
   input wire logic                      txLine,
   input wire logic                      txParityBit
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_rd_idle_zero: assert property (!$past(bus.rdStrobe) |-> rdData == 8'h00)
      else $error("read data not idle");
   a_idle_no_code: assert property ($past(bus.rdStrobe && bus.addr == 3'h0) && rdData[0] |-> rdData[5:1] == 5'h00)
      else $error("idle status with code");
   a_fifo_bits: assert property ($past(bus.rdStrobe && bus.addr == 3'h0) |-> rdData[7:6] == {2{$past(fifoEnabled)}})
      else $error("fifo bits wrong");
   a_flow_gated: assert property ($past(bus.rdStrobe && bus.addr == 3'h0 && !flowCtlEnable) |-> rdData[5:4] == 2'h0)
      else $error("flow bits while disabled");
   a_code_legal: assert property ($past(bus.rdStrobe && bus.addr == 3'h0) && !rdData[0]
      |-> rdData[5:1] inside {5'h03, 5'h02, 5'h06, 5'h01, 5'h00, 5'h08, 5'h10})
      else $error("illegal source code");
   a_tx_follow: assert property (txLine && !$past(sys_rst) |-> $past(txSerialIn))
      else $error("line high without data");
   a_len_range: assert property (format.dataBits inside {[4'h5:4'h8]})
      else $error("word length out of range");
   a_stop_half: assert property (format.stopHalves == 3'h3 |-> format.dataBits == 4'h5)
      else $error("one and a half stop bits on long word");
   a_par_off: assert property ($stable(format) && !format.parityOn |-> !txParityBit)
      else $error("parity bit while parity off");
   a_par_forced: assert property ($stable(format) && format.parityOn && format.parityForced
      |-> txParityBit == !format.paritySense)
      else $error("forced parity wrong");
endmodule : ufmt_core_sva
bind ufmt_core ufmt_core_sva ufmt_core_sva_i (.sys_clk, .sys_rst, .bus, .rdData, .fifoEnabled,
   .flowCtlEnable, .txSerialIn, .format, .txLine, .txParityBit);
`default_nettype wire

// ---- tb/ufmt_remote.sv ----
`timescale 1ns/100ps
`default_nettype none
module ufmt_remote (
   // Clock.
   input wire logic        sys_clk,
   // Format agreed with the local end, and the character to send.
   input wire logic [7:0]  fmtCtl,
   input wire logic [7:0]  charIn,
   input wire logic        corrupt,
   // Received character towards the block.
   output logic [7:0]      rxChar,
   output logic            rxParityIn
);
   // The parity sent is flipped on request so that parity checking can be seen to work.
   always_ff @(posedge sys_clk) begin
      rxChar     <= charIn;
      rxParityIn <= (fmtCtl[5] ? !fmtCtl[4] : (fmtCtl[4] ? ^charIn : ~^charIn)) ^ corrupt;
   end
endmodule : ufmt_remote
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                      sys_clk, sys_rst, xonSeen, fifoEnabled, flowCtlEnable, txSerialIn, prevSer;
   logic                      rxParityIn, corrupt, txLine, txParityBit, rxParityError, irq;
   logic [7:0]                rdData, txChar, rxChar, charIn, fmt, v, c;
   logic [31:0]               seed;
   ufmt_pkg::ufmt_bus_type    bus;
   ufmt_pkg::ufmt_event_type  events;
   ufmt_pkg::ufmt_format_type format;
   logic [7:0]                q[$];
   int                        fails, n_checks;

   ufmt_core ufmt_core_i (.sys_clk, .sys_rst, .bus, .rdData, .events, .xonSeen, .fifoEnabled,
      .flowCtlEnable, .txSerialIn, .txChar, .rxChar, .rxParityIn, .format, .txLine, .txParityBit,
      .rxParityError, .irq);
   ufmt_remote ufmt_remote_i (.sys_clk, .fmtCtl(fmt), .charIn, .corrupt, .rxChar, .rxParityIn);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic pexp(input logic [7:0] f, input logic [7:0] d);
      if (!f[3]) return 1'b0;
      if (f[5]) return !f[4];
      return f[4] ? ^d : ~^d;
   endfunction : pexp
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) bus.wrStrobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge sys_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk) bus.rdStrobe <= 1'b0;
      #1 chk("rdData", rdData, e);
   endtask : rd
   task automatic ev(input logic [6:0] e);
      @(posedge sys_clk) events <= e;
      @(posedge sys_clk) events <= '0;
      tick(2);
   endtask : ev
   task automatic rdq();
      foreach (q[i]) rd(3'h0, q[i]);
   endtask : rdq
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      prevSer    <= txSerialIn;
      txSerialIn <= ^rnd();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      finish_test();
   end
   initial begin
      {bus, events, xonSeen, fifoEnabled, flowCtlEnable, txChar, charIn, corrupt, fmt} = '0;
      seed = 32'h2504;
      fails = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(3'h0, 8'h01);
      rd(3'h1, 8'h00);
      rd(3'h5, 8'h00);
      chk("format", {format.dataBits, 1'b0, format.stopHalves}, 8'h52);
      fifoEnabled <= 1'b1;
      ev(7'h68); q = '{8'hC6, 8'hC4, 8'hC2, 8'hC1}; rdq();
      ev(7'h14); q = '{8'hCC, 8'hC0, 8'hC1}; rdq();
      ev(7'h08); ev(7'h40); q = '{8'hC2, 8'hC6, 8'hC1}; rdq();
      flowCtlEnable <= 1'b1;
      ev(7'h03); q = '{8'hD0, 8'hD0}; rdq();
      @(posedge sys_clk) xonSeen <= 1'b1;
      @(posedge sys_clk) xonSeen <= 1'b0;
      tick(2); q = '{8'hE0, 8'hC1}; rdq();
      flowCtlEnable <= 1'b0;
      ev(7'h01); rd(3'h0, 8'hC1);
      // Sticky event bits, mask and interrupt line.
      wr(3'h2, 8'h7F); wr(3'h3, 8'h08); rd(3'h3, 8'h08); ev(7'h08);
      chk("irq", {7'h0, irq}, 8'h01);
      rd(3'h2, 8'h08); wr(3'h2, 8'h08); tick(2);
      chk("irq", {7'h0, irq}, 8'h00);
      rd(3'h0, 8'hC2); ev(7'h40);
      chk("irq", {7'h0, irq}, 8'h00);
      rd(3'h2, 8'h40); rd(3'h0, 8'hC6);
      for (int i = 0; i < 8; i++) begin
         wr(3'h1, {5'h00, i[2:0]}); tick(2);
         chk("format", {format.dataBits, 1'b0, format.stopHalves}, {4'h5 + {2'h0, i[1:0]}, 1'b0,
            !i[2] ? 3'h2 : (i[1:0] == 2'h0 ? 3'h3 : 3'h4)});
      end
      repeat (4) begin
         v = 8'(rnd()) & 8'h7F; wr(3'h1, v); rd(3'h1, v);
      end
      wr(3'h1, 8'h80); tick(2); chk("divisor", {7'h0, format.divisorOpen}, 8'h01);
      wr(3'h1, 8'h40); tick(2); chk("txLine", {7'h0, txLine}, 8'h00);
      tick(3); chk("txLine", {7'h0, txLine}, 8'h00);
      for (int m = 0; m < 5; m++) begin
         v = (m == 4) ? 8'h03 : {2'h0, m[1:0], 4'hB};
         fmt <= v; wr(3'h1, v);
         for (int k = 0; k < 2; k++) begin
            c = 8'(rnd()); txChar <= c; charIn <= c; corrupt <= k[0]; tick(3);
            chk("parityFields", {5'h0, format.parityOn, format.parityForced, format.paritySense},
               {5'h0, v[3], v[5], v[4]});
            chk("txLine", {7'h0, txLine}, {7'h0, prevSer});
            chk("txParity", {7'h0, txParityBit}, {7'h0, pexp(v, c)});
            chk("rxParityError", {7'h0, rxParityError}, {7'h0, v[3] & k[0]});
         end
      end
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
